// File: gpd_div.sv
// Toggle divider: flips its output every HALF input ticks.
// Assumes i_tick is a one-cycle enable from the fast clock source.
`timescale 1ns/1ns
`default_nettype none
module gpd_div
  import gpd_pkg::*;
#(
  parameter int unsigned HALF = 2
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_ce,
  // Control
  input  wire logic i_run,
  input  wire logic i_tick,
  // Divided clock
  output logic      o_clk
);

  localparam int unsigned CW = $clog2(HALF + 1);

  if (HALF < 1) begin : g_bad_half
    $error("gpd_div: HALF must be at least 1");
  end

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          lvl;
  } gpd_div_st_t;

  gpd_div_st_t st_r;
  gpd_div_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (!i_run) begin
      st_nxt = '0;
    end else if (i_tick) begin
      if (st_r.cnt == CW'(HALF - 1)) begin
        st_nxt.cnt = '0;
        st_nxt.lvl = ~st_r.lvl;
      end else begin
        st_nxt.cnt = st_r.cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '0;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  assign o_clk = st_r.lvl;

endmodule : gpd_div
`default_nettype wire

// File: gpd_gate.sv
// Gate pre-driver gating logic with internal oscillator and clock dividers.
// Assumes gate inputs and enables are synchronous to i_clk and that the
// fault logic outside supplies the per-group enables.
`timescale 1ns/1ns
`default_nettype none
module gpd_gate
  import gpd_pkg::*;
(
  // Clock, reset, enable
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_ce,
  input  wire logic       i_por_n,
  // Fault-logic enables and status
  input  wire logic       i_gate_en_relay,
  input  wire logic [2:0] i_gate_en_phase,
  input  wire logic       i_vcc_uv,
  // Configuration
  input  wire logic       i_inhibit_mode,
  input  wire logic [1:0] i_limit_sel,
  input  wire logic [1:0] i_clk_sel,
  // Relay inputs
  input  wire logic       i_power_relay1_in,
  input  wire logic       i_power_relay2_in,
  input  wire logic       i_motor_relay_u_in,
  input  wire logic       i_motor_relay_v_in,
  input  wire logic       i_motor_relay_w_in,
  // Half-bridge inputs
  input  wire logic       i_high_side_u_in,
  input  wire logic       i_high_side_v_in,
  input  wire logic       i_high_side_w_in,
  input  wire logic       i_low_side_u_in,
  input  wire logic       i_low_side_v_in,
  input  wire logic       i_low_side_w_in,
  // Relay outputs
  output logic            o_power_relay1_out,
  output logic            o_power_relay2_out,
  output logic            o_motor_relay_u_out,
  output logic            o_motor_relay_v_out,
  output logic            o_motor_relay_w_out,
  // Half-bridge outputs
  output logic            o_high_side_u_out,
  output logic            o_high_side_v_out,
  output logic            o_high_side_w_out,
  output logic            o_low_side_u_out,
  output logic            o_low_side_v_out,
  output logic            o_low_side_w_out,
  // Drive strength and inhibit status per phase (bit 0 = U)
  output logic [2:0]      o_full_drive,
  output logic [2:0]      o_inhibit_seen,
  // Clocks
  output logic            o_sys_clock_fast,
  output logic            o_alarm_filter_clock,
  output logic            o_pump_clock,
  output logic            o_self_test_clock,
  output logic            o_selected_clock_pin
);

  typedef struct packed {
    logic [TICK_W-1:0]                osc_cnt;
    logic                             fast_lvl;
    logic                             fast_tick;
    logic [NUM_PHASES-1:0]            inh;
    logic [NUM_PHASES-1:0]            prev_hs;
    logic [NUM_PHASES-1:0]            prev_ls;
    logic [NUM_PHASES-1:0][LIMIT_W-1:0] lim_cnt;
    logic [NUM_PHASES-1:0]            full;
    logic                             cko;
  } gpd_gate_st_t;

  gpd_gate_st_t st_r;
  gpd_gate_st_t st_nxt;

  logic [2:0] hs_in;
  logic [2:0] ls_in;
  logic [2:0] hs_out;
  logic [2:0] ls_out;
  logic       relay_on;
  logic       alarm_clk;
  logic       pump_clk;
  logic       test_clk;
  logic [LIMIT_W-1:0] lim_load;

  assign hs_in    = {i_high_side_w_in, i_high_side_v_in, i_high_side_u_in};
  assign ls_in    = {i_low_side_w_in, i_low_side_v_in, i_low_side_u_in};
  assign relay_on = i_gate_en_relay;

  // Gating stays combinational so a disable from the fault logic cuts
  // the drive in the same cycle rather than one clock later.
  assign o_power_relay1_out  = i_power_relay1_in & relay_on;
  assign o_power_relay2_out  = i_power_relay2_in & relay_on;
  assign o_motor_relay_u_out = i_motor_relay_u_in & relay_on;
  assign o_motor_relay_v_out = i_motor_relay_v_in & relay_on;
  assign o_motor_relay_w_out = i_motor_relay_w_in & relay_on;

  always_comb begin
    for (int p = 0; p < NUM_PHASES; p++) begin
      hs_out[p] = i_gate_en_phase[p] & hs_in[p] & ~ls_in[p] & ~st_r.inh[p];
      ls_out[p] = i_gate_en_phase[p] & ls_in[p] & ~hs_in[p] & ~st_r.inh[p];
    end
  end

  assign o_high_side_u_out = hs_out[0];
  assign o_high_side_v_out = hs_out[1];
  assign o_high_side_w_out = hs_out[2];
  assign o_low_side_u_out  = ls_out[0];
  assign o_low_side_v_out  = ls_out[1];
  assign o_low_side_w_out  = ls_out[2];

  always_comb begin
    unique case (i_limit_sel)
      LIM_SEL_NOM:   lim_load = LIMIT_W'(LIMIT_NOM_CYC);
      LIM_SEL_SHORT: lim_load = LIMIT_W'(LIMIT_SHORT_CYC);
      LIM_SEL_LONG:  lim_load = LIMIT_W'(LIMIT_LONG_CYC);
      LIM_SEL_NONE:  lim_load = '0;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.fast_tick = 1'b0;
    if (!i_por_n) begin
      st_nxt.osc_cnt  = '0;
      st_nxt.fast_lvl = 1'b0;
    end else begin
      if (st_r.osc_cnt == TICK_W'(FAST_DIV - 1)) begin
        st_nxt.osc_cnt   = '0;
        st_nxt.fast_tick = 1'b1;
      end else begin
        st_nxt.osc_cnt = st_r.osc_cnt + TICK_W'(1);
      end
      // High on counts 1..FAST_HIGH so the first pulse after either reset is full width
      st_nxt.fast_lvl = (st_nxt.osc_cnt != '0) && (st_nxt.osc_cnt <= TICK_W'(FAST_HIGH));
    end

    for (int p = 0; p < NUM_PHASES; p++) begin
      // Latch mode keeps the phase off until both inputs return low;
      // a new both-high pair wins over the release in the same cycle.
      if (i_inhibit_mode == INH_MODE_LATCH) begin
        if (hs_in[p] & ls_in[p]) begin
          st_nxt.inh[p] = 1'b1;
        end else if (!hs_in[p] && !ls_in[p]) begin
          st_nxt.inh[p] = 1'b0;
        end
      end else begin
        st_nxt.inh[p] = 1'b0;
      end

      st_nxt.prev_hs[p] = hs_out[p];
      st_nxt.prev_ls[p] = ls_out[p];
      if ((hs_out[p] != st_r.prev_hs[p]) || (ls_out[p] != st_r.prev_ls[p])) begin
        st_nxt.lim_cnt[p] = lim_load;
      end else if (st_r.lim_cnt[p] != '0) begin
        st_nxt.lim_cnt[p] = st_r.lim_cnt[p] - LIMIT_W'(1);
      end
      if (i_vcc_uv) begin
        st_nxt.full[p] = 1'b0;
      end else if (i_limit_sel == LIM_SEL_NONE) begin
        st_nxt.full[p] = 1'b1;
      end else begin
        st_nxt.full[p] = (st_nxt.lim_cnt[p] != '0);
      end
    end

    unique case (i_clk_sel)
      CKO_SEL_FAST: st_nxt.cko = st_nxt.fast_lvl;
      CKO_SEL_PUMP: st_nxt.cko = pump_clk;
      CKO_SEL_TEST: st_nxt.cko = test_clk;
      default:      st_nxt.cko = st_nxt.fast_lvl;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '0;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  gpd_div #(.HALF(ALARM_HALF)) u_div_alarm (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_ce   (i_ce),
    .i_run  (i_por_n),
    .i_tick (st_r.fast_tick),
    .o_clk  (alarm_clk)
  );

  gpd_div #(.HALF(PUMP_HALF)) u_div_pump (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_ce   (i_ce),
    .i_run  (i_por_n),
    .i_tick (st_r.fast_tick),
    .o_clk  (pump_clk)
  );

  gpd_div #(.HALF(TEST_HALF)) u_div_test (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_ce   (i_ce),
    .i_run  (i_por_n),
    .i_tick (st_r.fast_tick),
    .o_clk  (test_clk)
  );

  assign o_full_drive         = st_r.full;
  assign o_inhibit_seen       = st_r.inh;
  assign o_sys_clock_fast     = st_r.fast_lvl;
  assign o_alarm_filter_clock = alarm_clk;
  assign o_pump_clock         = pump_clk;
  assign o_self_test_clock    = test_clk;
  assign o_selected_clock_pin = st_r.cko;

endmodule : gpd_gate
`default_nettype wire

// File: gpd_gate_chk.sv
// Checker for the gating and clock divider block.
// Bound to gpd_gate below; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module gpd_gate_chk
  import gpd_pkg::*;
(
  input wire logic       i_clk, i_rst, i_ce, i_por_n, i_gate_en_relay, i_vcc_uv, i_inhibit_mode,
  input wire logic [2:0] i_gate_en_phase,
  input wire logic [1:0] i_limit_sel, i_clk_sel,
  input wire logic       i_power_relay1_in, i_motor_relay_u_in, i_motor_relay_v_in, i_motor_relay_w_in,
  input wire logic       i_high_side_u_in, i_low_side_u_in, o_power_relay1_out, o_motor_relay_u_out,
  input wire logic       o_motor_relay_v_out, o_motor_relay_w_out, o_high_side_u_out, o_low_side_u_out,
  input wire logic [2:0] o_full_drive, o_inhibit_seen,
  input wire logic       o_sys_clock_fast, o_alarm_filter_clock, o_pump_clock, o_self_test_clock,
  input wire logic       o_selected_clock_pin
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  chk_power_relay: assert property (o_power_relay1_out == (i_power_relay1_in & i_gate_en_relay))
    else $error("power relay output differs from input and enable");
  chk_motor_relay: assert property ({o_motor_relay_u_out, o_motor_relay_v_out, o_motor_relay_w_out} ==
    ({i_motor_relay_u_in, i_motor_relay_v_in, i_motor_relay_w_in} & {3{i_gate_en_relay}}))
    else $error("motor relay outputs differ from inputs and enable");
  chk_phase_off: assert property (!i_gate_en_phase[0] |-> !o_high_side_u_out && !o_low_side_u_out)
    else $error("phase outputs driven while phase disabled");
  chk_both_high: assert property (i_high_side_u_in && i_low_side_u_in |-> !o_high_side_u_out && !o_low_side_u_out)
    else $error("both-high input pair not blocked");
  chk_follow_high: assert property (!i_inhibit_mode && !o_inhibit_seen[0] && i_gate_en_phase[0] &&
    i_high_side_u_in && !i_low_side_u_in |-> o_high_side_u_out)
    else $error("high side output does not follow input at once");
  chk_uv_limit: assert property (i_vcc_uv && i_ce |=> o_full_drive == 3'h0)
    else $error("full drive kept during undervoltage");
  chk_no_limit: assert property (i_limit_sel == LIM_SEL_NONE && !i_vcc_uv && i_ce |=> o_full_drive == 3'h7)
    else $error("full drive missing with no limit time");
  chk_por_hold: assert property (!i_por_n && i_ce |=> !o_sys_clock_fast && !o_alarm_filter_clock &&
    !o_pump_clock && !o_self_test_clock)
    else $error("clocks running while power-on reset held");
  // A low clock enable stretches the pulse on purpose, so such attempts are dropped
  chk_fast_high: assert property (@(posedge i_clk) disable iff (i_rst || !i_por_n || !i_ce)
    $rose(o_sys_clock_fast) |-> ##11 o_sys_clock_fast ##1 !o_sys_clock_fast)
    else $error("fast clock high time wrong");
  chk_pin_pump: assert property (i_clk_sel == CKO_SEL_PUMP && $past(i_clk_sel) == CKO_SEL_PUMP
    |-> o_selected_clock_pin == $past(o_pump_clock))
    else $error("clock pin does not carry pump clock");

  cov_latch: cover property ($rose(o_inhibit_seen[0]));
  cov_full: cover property ($rose(o_full_drive[0]));
  cov_pump_pin: cover property (i_clk_sel == CKO_SEL_PUMP && $rose(o_selected_clock_pin));
endmodule : gpd_gate_chk

bind gpd_gate gpd_gate_chk u_gpd_gate_chk (
  .i_clk, .i_rst, .i_ce, .i_por_n, .i_gate_en_relay, .i_vcc_uv, .i_inhibit_mode, .i_gate_en_phase,
  .i_limit_sel, .i_clk_sel, .i_power_relay1_in, .i_motor_relay_u_in, .i_motor_relay_v_in,
  .i_motor_relay_w_in, .i_high_side_u_in, .i_low_side_u_in, .o_power_relay1_out, .o_motor_relay_u_out,
  .o_motor_relay_v_out, .o_motor_relay_w_out, .o_high_side_u_out, .o_low_side_u_out, .o_full_drive,
  .o_inhibit_seen, .o_sys_clock_fast, .o_alarm_filter_clock, .o_pump_clock, .o_self_test_clock,
  .o_selected_clock_pin
);
`default_nettype wire

// File: gpd_gate_tb.sv
// Self-checking bench for the gating and clock divider block.
// Assumes the controller model drives the gate pins one edge after the pattern.
`timescale 1ns/1ns
`default_nettype none
module gpd_gate_tb
  import gpd_pkg::*;
;
  logic i_clk, i_rst, i_ce, i_por_n, en_r, uv, mode, fast, alarm, pump, test, pin;
  logic [2:0]  en_ph, hs, ls, full, seen;
  logic [1:0]  lim, cks;
  logic [10:0] cmd, pins;
  logic [4:0]  rel;
  int fail_count, total_checks, seed, i, j, k, p;
  logic [31:0] c, e;
  logic [1:0]  lsel[3] = '{LIM_SEL_NOM, LIM_SEL_SHORT, LIM_SEL_LONG};
  int          lcyc[3] = '{LIMIT_NOM_CYC, LIMIT_SHORT_CYC, LIMIT_LONG_CYC};
  int          per_x[4] = '{FAST_DIV, CLK_HZ / ALARM_HZ, CLK_HZ / PUMP_HZ, CLK_HZ / TEST_HZ};
  int          pin_src[4] = '{0, 2, 3, 0};

  gpd_mcu_model u_gpd_mcu_model (.i_clk(i_clk), .i_cmd(cmd), .o_pins(pins));
  gpd_gate u_gpd_gate (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_por_n(i_por_n),
    .i_gate_en_relay(en_r), .i_gate_en_phase(en_ph), .i_vcc_uv(uv), .i_inhibit_mode(mode),
    .i_limit_sel(lim), .i_clk_sel(cks), .i_power_relay1_in(pins[0]), .i_power_relay2_in(pins[1]),
    .i_motor_relay_u_in(pins[2]), .i_motor_relay_v_in(pins[3]), .i_motor_relay_w_in(pins[4]),
    .i_high_side_u_in(pins[5]), .i_high_side_v_in(pins[6]), .i_high_side_w_in(pins[7]),
    .i_low_side_u_in(pins[8]), .i_low_side_v_in(pins[9]), .i_low_side_w_in(pins[10]),
    .o_power_relay1_out(rel[0]), .o_power_relay2_out(rel[1]), .o_motor_relay_u_out(rel[2]),
    .o_motor_relay_v_out(rel[3]), .o_motor_relay_w_out(rel[4]), .o_high_side_u_out(hs[0]),
    .o_high_side_v_out(hs[1]), .o_high_side_w_out(hs[2]), .o_low_side_u_out(ls[0]),
    .o_low_side_v_out(ls[1]), .o_low_side_w_out(ls[2]), .o_full_drive(full), .o_inhibit_seen(seen),
    .o_sys_clock_fast(fast), .o_alarm_filter_clock(alarm), .o_pump_clock(pump),
    .o_self_test_clock(test), .o_selected_clock_pin(pin));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic conclude;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  function automatic logic [10:0] expo(input logic [10:0] cv, input logic er, input logic [2:0] ep);
    return {cv[10:8] & ~cv[7:5] & ep, cv[7:5] & ~cv[10:8] & ep, cv[4:0] & {5{er}}};
  endfunction : expo

  function automatic logic sig(input int n);
    case (n)
      0: return fast;
      1: return alarm;
      2: return pump;
      3: return test;
      default: return pin;
    endcase
  endfunction : sig

  task automatic drive(input logic [10:0] cv, input logic er, input logic [2:0] ep);
    @(posedge i_clk);
    cmd <= cv;
    en_r <= er;
    en_ph <= ep;
    @(posedge i_clk);
    @(negedge i_clk);
  endtask : drive

  // Cycles between two rising edges; a missing edge ends the run
  task automatic period(input int n, output int pc);
    int r;
    logic a;
    r = 0;
    pc = 0;
    a = sig(n);
    for (int t = 0; t < 14000 && r < 2; t++) begin
      @(negedge i_clk);
      if (r == 1) pc++;
      if (sig(n) && !a) r++;
      a = sig(n);
    end
    if (r < 2) begin
      fail_count++;
      conclude();
    end
  endtask : period

  initial begin
    seed = 60; fail_count = 0; total_checks = 0;
    i_rst = 1'b1; i_ce = 1'b1; i_por_n = 1'b0; cmd = '0; en_r = 1'b0; en_ph = '0;
    uv = 1'b0; mode = INH_MODE_FOLLOW; lim = LIM_SEL_NOM; cks = CKO_SEL_FAST;
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    check({fast, alarm, pump, test}, 0);
    @(posedge i_clk);
    i_por_n <= 1'b1;
    for (i = 0; i < 300; i++) begin
      c = $random(seed);
      e = $random(seed);
      if (i == 0) begin c = 11'h7ff; e = 4'hf; end
      if (i == 1) begin c = 11'h7ff; e = 4'h0; end
      drive(c[10:0], e[3], e[2:0]);
      check({ls, hs, rel}, expo(c[10:0], e[3], e[2:0]));
    end
    @(posedge i_clk);
    mode <= INH_MODE_LATCH;
    drive(11'h120, 1'b1, 3'h7);
    drive(11'h020, 1'b1, 3'h7);
    check({seen[0], hs[0]}, 2'h2);
    drive(11'h000, 1'b1, 3'h7);
    drive(11'h020, 1'b1, 3'h7);
    check({seen[0], hs[0]}, 2'h1);
    @(posedge i_clk);
    mode <= INH_MODE_FOLLOW;
    for (i = 0; i < 3; i++) begin
      @(posedge i_clk);
      lim <= lsel[i];
      drive(11'h000, 1'b1, 3'h7);
      repeat (1700) @(posedge i_clk);
      drive(11'h020, 1'b1, 3'h7);
      k = 0;
      for (j = 0; j < 2000; j++) begin
        @(negedge i_clk);
        if (full[0]) k++;
        else if (k > 0) j = 2000;
      end
      check(k >= lcyc[i] - 1 && k <= lcyc[i] + 1, 1);
    end
    @(posedge i_clk);
    lim <= LIM_SEL_NONE;
    drive(11'h000, 1'b1, 3'h7);
    repeat (3) @(negedge i_clk);
    check(full, 3'h7);
    @(posedge i_clk);
    uv <= 1'b1;
    repeat (2) @(negedge i_clk);
    check(full, 3'h0);
    @(posedge i_clk);
    uv <= 1'b0;
    for (i = 0; i < 4; i++) begin
      period(i, p);
      check(p, per_x[i]);
    end
    for (i = 0; i < 4; i++) begin
      @(posedge i_clk);
      cks <= i[1:0];
      period(4, p);
      period(4, p);
      check(p, per_x[pin_src[i]]);
    end
    // Clock enable low must freeze the oscillator, dividers and clock pin
    @(posedge i_clk);
    i_ce <= 1'b0;
    @(negedge i_clk);
    c = {fast, alarm, pump, test, pin};
    repeat (30) @(negedge i_clk);
    check({fast, alarm, pump, test, pin}, c);
    @(posedge i_clk);
    i_ce <= 1'b1;
    period(0, p);
    check(p, per_x[0]);
    conclude();
  end
endmodule : gpd_gate_tb
`default_nettype wire

// File: gpd_mcu_model.sv
// Model of the controller that drives the gate input pins.
// Assumes the bench hands it a pin pattern: bit0..4 relays, 5..7 high U/V/W, 8..10 low U/V/W.
`timescale 1ns/1ns
`default_nettype none
module gpd_mcu_model (
  // Clock and pattern
  input  wire logic        i_clk,
  input  wire logic [10:0] i_cmd,
  // Gate input pins
  output logic [10:0]      o_pins
);
  // Pins move only just after an edge, as a port register would
  always_ff @(posedge i_clk) begin
    o_pins <= i_cmd;
  end
endmodule : gpd_mcu_model
`default_nettype wire

// File: gpd_pkg.sv
// Package for the gate pre-driver gating and clock divider block.
// Assumes a 100 MHz system clock; all counts are derived from it here.
package gpd_pkg;

  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS = 10;

  // Internal oscillator and derived clocks
  localparam int unsigned FAST_HZ      = 4_000_000;
  localparam int unsigned ALARM_HZ     = 1_000_000;
  localparam int unsigned PUMP_HZ      = 500_000;
  localparam int unsigned TEST_HZ      = 16_000;
  localparam int unsigned FAST_DIV     = CLK_HZ / FAST_HZ;
  localparam int unsigned FAST_HIGH    = FAST_DIV / 2;
  localparam int unsigned ALARM_HALF   = FAST_HZ / ALARM_HZ / 2;
  localparam int unsigned PUMP_HALF    = FAST_HZ / PUMP_HZ / 2;
  localparam int unsigned TEST_HALF    = FAST_HZ / TEST_HZ / 2;
  localparam int unsigned TICK_W       = 5;

  // Current-limit times, longest time so rounded down
  localparam int unsigned LIMIT_NOM_NS   = 8000;
  localparam int unsigned LIMIT_SHORT_NS = 4000;
  localparam int unsigned LIMIT_LONG_NS  = 16000;
  localparam int unsigned LIMIT_NOM_CYC   = LIMIT_NOM_NS / CLK_PERIOD_NS;
  localparam int unsigned LIMIT_SHORT_CYC = LIMIT_SHORT_NS / CLK_PERIOD_NS;
  localparam int unsigned LIMIT_LONG_CYC  = LIMIT_LONG_NS / CLK_PERIOD_NS;
  localparam int unsigned LIMIT_W         = 11;

  // Current-limit time select
  localparam logic [1:0] LIM_SEL_NOM   = 2'h0;
  localparam logic [1:0] LIM_SEL_SHORT = 2'h1;
  localparam logic [1:0] LIM_SEL_LONG  = 2'h2;
  localparam logic [1:0] LIM_SEL_NONE  = 2'h3;

  // Clock output select
  localparam logic [1:0] CKO_SEL_FAST = 2'h0;
  localparam logic [1:0] CKO_SEL_PUMP = 2'h1;
  localparam logic [1:0] CKO_SEL_TEST = 2'h2;

  // Inhibit reaction modes
  localparam logic INH_MODE_FOLLOW = 1'h0;
  localparam logic INH_MODE_LATCH  = 1'h1;

  localparam int unsigned NUM_PHASES = 3;

endpackage : gpd_pkg
